// >>> rtl/fbm_fifo.sv
// long-word fifo with delayed visibility toward each side
`timescale 1ns/1ps
module fbm_fifo
  import fbm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic            push_i,
  input  wire logic [LW_W-1:0] push_data_i,
  input  wire logic            pop_i,
  input  wire logic            free_i,
  output logic      [LW_W-1:0] head_o,
  output logic                 avail_o,
  output logic                 avail_nx_o,
  output logic                 room_nx_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [LW_W-1:0] mem [DEPTH];
  logic [AW-1:0]   wptr_q;
  logic [AW-1:0]   rptr_q;
  logic [CW-1:0]   vis_q;
  logic [CW-1:0]   vis_d;
  logic [CW-1:0]   room_q;
  logic [CW-1:0]   room_d;
  logic            push_dly_q;
  logic            free_dly_q;

  // a push reaches the reader a clock late, a free reaches the writer
  // a clock late: each side only sees what has crossed
  assign vis_d      = vis_q + CW'(push_dly_q) - CW'(pop_i);
  assign room_d     = room_q + CW'(free_dly_q) - CW'(push_i);
  assign head_o     = mem[rptr_q];
  assign avail_o    = vis_q != '0;
  assign avail_nx_o = vis_d != '0;
  assign room_nx_o  = room_d != '0;

  always_ff @(posedge clk_i) begin
    if (ce_i && push_i) begin
      mem[wptr_q] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      vis_q      <= '0;
      room_q     <= CW'(DEPTH);
      push_dly_q <= 1'b0;
      free_dly_q <= 1'b0;
    end else if (ce_i) begin
      wptr_q     <= push_i ? wptr_q + AW'(1) : wptr_q;
      rptr_q     <= pop_i ? rptr_q + AW'(1) : rptr_q;
      vis_q      <= vis_d;
      room_q     <= room_d;
      push_dly_q <= push_i;
      free_dly_q <= free_i;
    end
  end
endmodule

// >>> rtl/fbm_pkg.sv
// constants shared by the bus-matching fifo pair
package fbm_pkg;

  localparam int LW_W           = 36;   // long word held in both fifos
  localparam int NW_W           = 18;   // narrow port width, word mode
  localparam int BYTE_W         = 9;    // narrow port width, byte mode
  localparam int FIFO_DEPTH_DEF = 256;  // long words per fifo

  // narrow piece counters: index of the last piece of a long word
  localparam logic [1:0] WORD_LAST = 2'h1;
  localparam logic [1:0] BYTE_LAST = 2'h3;

  // fall-through load happens on the third port clock after the write
  localparam int FT_LOAD_CYCLES = 3;
  localparam int EF_CYCLES      = 1;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h4;
  localparam logic [ADDR_W-1:0] FLAGS_OFS  = 4'h8;

  // event bits, same layout in status and mask
  localparam int EV_W          = 6;
  localparam int EV_TX_LW_DONE = 0;
  localparam int EV_RX_LW_DONE = 1;
  localparam int EV_WIDE_WR_RJ = 2;
  localparam int EV_RX_WR_RJ   = 3;
  localparam int EV_TX_RD_RJ   = 4;
  localparam int EV_WIDE_RD_RJ = 5;
  localparam logic [EV_W-1:0] STATUS_RST = 6'h00;
  localparam logic [EV_W-1:0] MASK_RST   = 6'h00;

  // configuration pins after synchronisation
  localparam int CFG_W      = 4;
  localparam int CFG_TX_BYTE = 0;
  localparam int CFG_RX_BYTE = 1;
  localparam int CFG_BIG     = 2;
  localparam int CFG_FT      = 3;

endpackage

// >>> rtl/fbm_sync.sv
// two-flop synchroniser for static configuration pins
`timescale 1ns/1ps
module fbm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // no reset: the pins must be seen while the block is still in reset
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// >>> rtl/fbm_top.sv
// bus-matching fifo pair: wide port, narrow transmit and receive ports
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fbm_top
  import fbm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic              CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              CE_I,
  input  wire logic              TX_PORT_WIDTH_SELECT_I,
  input  wire logic              RX_PORT_WIDTH_SELECT_I,
  input  wire logic              ENDIAN_ORDER_SELECT_I,
  input  wire logic              FALL_THROUGH_MODE_I,
  input  wire logic              WIDE_WR_I,
  input  wire logic [LW_W-1:0]   WIDE_WDATA_I,
  input  wire logic              WIDE_RD_I,
  output logic      [LW_W-1:0]   WIDE_RDATA_O,
  output logic                   WIDE_PORT_INPUT_READY_O,
  output logic                   WIDE_PORT_OUTPUT_READY_O,
  output logic                   WIDE_PORT_EMPTY_FLAG_N_O,
  input  wire logic              TX_RD_I,
  output logic      [NW_W-1:0]   TX_DATA_O,
  output logic                   TX_PORT_OUTPUT_READY_O,
  output logic                   TX_PORT_EMPTY_FLAG_N_O,
  input  wire logic              RX_WR_I,
  input  wire logic [NW_W-1:0]   RX_DATA_I,
  output logic                   RX_INPUT_READY_O,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  output logic                   IRQ_O
);

  logic [CFG_W-1:0] cfg_s;
  logic             big_q;
  logic             ft_q;
  logic             tx_byte;
  logic             rx_byte;

  // pick one narrow piece of a long word
  function automatic logic [NW_W-1:0] piece_of(
    input logic [LW_W-1:0] w,
    input logic [1:0]      k,
    input logic            byte_m,
    input logic            big
  );
    logic [1:0] s;
    s = big ? ((byte_m ? BYTE_LAST : WORD_LAST) - k) : k;
    if (byte_m) begin
      piece_of = {{(NW_W-BYTE_W){1'b0}}, w[BYTE_W*s +: BYTE_W]};
    end else begin
      piece_of = w[NW_W*s[0] +: NW_W];
    end
  endfunction

  // drop one narrow piece into its slot of a long word
  function automatic logic [LW_W-1:0] merge_in(
    input logic [LW_W-1:0] w,
    input logic [NW_W-1:0] d,
    input logic [1:0]      k,
    input logic            byte_m,
    input logic            big
  );
    logic [1:0]      s;
    logic [LW_W-1:0] r;
    s = big ? ((byte_m ? BYTE_LAST : WORD_LAST) - k) : k;
    r = w;
    if (byte_m) begin
      r[BYTE_W*s +: BYTE_W] = d[BYTE_W-1:0];
    end else begin
      r[NW_W*s[0] +: NW_W] = d;
    end
    merge_in = r;
  endfunction

  fbm_sync #(
    .W (CFG_W)
  ) u_cfg_sync (
    .clk_i (CLK_I),
    .ce_i  (CE_I),
    .d_i   ({FALL_THROUGH_MODE_I, ENDIAN_ORDER_SELECT_I,
             RX_PORT_WIDTH_SELECT_I, TX_PORT_WIDTH_SELECT_I}),
    .q_o   (cfg_s)
  );

  // width selects are used live; the host keeps them static
  assign tx_byte = cfg_s[CFG_TX_BYTE];
  assign rx_byte = cfg_s[CFG_RX_BYTE];

  // fifo1: wide port writes, transmit port reads
  logic            f1_push;
  logic            f1_pop;
  logic            f1_free;
  logic [LW_W-1:0] f1_head;
  logic            f1_avail;
  logic            f1_avail_nx;
  logic            f1_room_nx;
  logic            f1_seen_q;
  // fifo2: receive port writes, wide port reads
  logic            f2_push;
  logic            f2_pop;
  logic [LW_W-1:0] f2_head;
  logic            f2_avail;
  logic            f2_avail_nx;
  logic            f2_room_nx;
  logic            f2_seen_q;
  logic [LW_W-1:0] f2_wdata;
  fbm_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo1 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .ce_i        (CE_I),
    .push_i      (f1_push),
    .push_data_i (WIDE_WDATA_I),
    .pop_i       (f1_pop),
    .free_i      (f1_free),
    .head_o      (f1_head),
    .avail_o     (f1_avail),
    .avail_nx_o  (f1_avail_nx),
    .room_nx_o   (f1_room_nx)
  );

  fbm_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo2 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .ce_i        (CE_I),
    .push_i      (f2_push),
    .push_data_i (f2_wdata),
    .pop_i       (f2_pop),
    .free_i      (f2_pop),
    .head_o      (f2_head),
    .avail_o     (f2_avail),
    .avail_nx_o  (f2_avail_nx),
    .room_nx_o   (f2_room_nx)
  );

  // wide port write into fifo1
  assign f1_push = CE_I && WIDE_WR_I && WIDE_PORT_INPUT_READY_O;
  // transmit port
  logic [1:0]      tx_idx_q;
  logic [1:0]      tx_idx_d;
  logic [1:0]      tx_last_idx;
  logic [1:0]      tx_sel;
  logic [LW_W-1:0] tx_lw_q;
  logic [LW_W-1:0] tx_src;
  logic            tx_take;
  logic            tx_first;
  logic            tx_last_rd;
  logic            tx_load;
  logic            tx_upd;
  logic            tx_or_d;
  logic            tx_ef_n_d;
  assign tx_last_idx = tx_byte ? BYTE_LAST : WORD_LAST;
  assign tx_take     = CE_I && TX_RD_I &&
                       (ft_q ? TX_PORT_OUTPUT_READY_O
                             : TX_PORT_EMPTY_FLAG_N_O);
  assign tx_last_rd  = tx_take && tx_idx_q == tx_last_idx;
  // standard mode fetches the long word on its first narrow read
  assign tx_first    = !ft_q && tx_take && tx_idx_q == 2'h0;
  assign tx_load     = CE_I && ft_q && f1_avail && f1_seen_q &&
                       (!TX_PORT_OUTPUT_READY_O || tx_last_rd);
  assign f1_pop      = tx_first || tx_load;
  assign f1_free     = tx_last_rd;
  assign tx_src      = f1_pop ? f1_head : tx_lw_q;
  assign tx_sel      = f1_pop ? 2'h0
                     : (ft_q ? tx_idx_q + 2'h1 : tx_idx_q);
  assign tx_upd      = f1_pop || (tx_take && (!ft_q || !tx_last_rd));
  assign tx_idx_d    = tx_load ? 2'h0
                     : !tx_take ? tx_idx_q
                     : (!ft_q && tx_last_rd) ? 2'h0
                     : tx_idx_q + 2'h1;
  assign tx_or_d     = tx_load ? 1'b1
                     : tx_last_rd ? 1'b0
                     : TX_PORT_OUTPUT_READY_O;
  assign tx_ef_n_d   = (tx_idx_d != 2'h0) || f1_avail_nx;

  // receive port gathers pieces before committing to fifo2
  logic [1:0]      rx_idx_q;
  logic [1:0]      rx_last_idx;
  logic [LW_W-1:0] rx_lw_q;
  logic            rx_take;
  assign rx_last_idx = rx_byte ? BYTE_LAST : WORD_LAST;
  assign rx_take     = CE_I && RX_WR_I && RX_INPUT_READY_O;
  assign f2_wdata    = merge_in(rx_lw_q, RX_DATA_I, rx_idx_q, rx_byte,
                                big_q);
  assign f2_push     = rx_take && rx_idx_q == rx_last_idx;

  // wide port read from fifo2
  logic wd_take;
  logic wd_load;
  assign wd_take = CE_I && WIDE_RD_I &&
                   (ft_q ? WIDE_PORT_OUTPUT_READY_O
                         : WIDE_PORT_EMPTY_FLAG_N_O);
  assign wd_load = CE_I && ft_q && f2_avail && f2_seen_q &&
                   (!WIDE_PORT_OUTPUT_READY_O || wd_take);
  assign f2_pop  = (!ft_q && wd_take) || wd_load;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      // endian and timing mode are caught while reset is held
      big_q <= cfg_s[CFG_BIG];
      ft_q  <= cfg_s[CFG_FT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_idx_q               <= 2'h0;
      tx_lw_q                <= '0;
      TX_DATA_O              <= '0;
      TX_PORT_OUTPUT_READY_O <= 1'b0;
      TX_PORT_EMPTY_FLAG_N_O <= 1'b0;
      f1_seen_q              <= 1'b0;
    end else if (CE_I) begin
      tx_idx_q               <= tx_idx_d;
      tx_lw_q                <= tx_src;
      TX_DATA_O              <= tx_upd ? piece_of(tx_src, tx_sel, tx_byte,
                                 big_q) : TX_DATA_O;
      TX_PORT_OUTPUT_READY_O <= tx_or_d;
      TX_PORT_EMPTY_FLAG_N_O <= tx_ef_n_d;
      f1_seen_q              <= f1_avail;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_idx_q                 <= 2'h0;
      rx_lw_q                  <= '0;
      RX_INPUT_READY_O         <= 1'b0;
      WIDE_PORT_INPUT_READY_O  <= 1'b0;
      WIDE_RDATA_O             <= '0;
      WIDE_PORT_OUTPUT_READY_O <= 1'b0;
      WIDE_PORT_EMPTY_FLAG_N_O <= 1'b0;
      f2_seen_q                <= 1'b0;
    end else if (CE_I) begin
      if (rx_take) begin
        rx_idx_q <= f2_push ? 2'h0 : rx_idx_q + 2'h1;
        rx_lw_q  <= f2_wdata;
      end
      RX_INPUT_READY_O         <= f2_room_nx;
      WIDE_PORT_INPUT_READY_O  <= f1_room_nx;
      WIDE_RDATA_O             <= f2_pop ? f2_head : WIDE_RDATA_O;
      WIDE_PORT_OUTPUT_READY_O <= wd_load ? 1'b1
                                : wd_take ? 1'b0
                                : WIDE_PORT_OUTPUT_READY_O;
      WIDE_PORT_EMPTY_FLAG_N_O <= f2_avail_nx;
      f2_seen_q                <= f2_avail;
    end
  end

  // status, mask and interrupt
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   status_q;
  logic [EV_W-1:0]   status_d;
  logic [EV_W-1:0]   mask_q;
  logic [EV_W-1:0]   mask_d;
  logic [EV_W-1:0]   clr;
  logic [DATA_W-1:0] flags;
  logic [DATA_W-1:0] rd_mux;
  logic              wr_status;
  logic              wr_mask;
  assign ev[EV_TX_LW_DONE] = f1_free;
  assign ev[EV_RX_LW_DONE] = f2_push;
  assign ev[EV_WIDE_WR_RJ] = CE_I && WIDE_WR_I && !WIDE_PORT_INPUT_READY_O;
  assign ev[EV_RX_WR_RJ]   = CE_I && RX_WR_I && !RX_INPUT_READY_O;
  assign ev[EV_TX_RD_RJ]   = CE_I && TX_RD_I && !tx_take;
  assign ev[EV_WIDE_RD_RJ] = CE_I && WIDE_RD_I && !wd_take;
  assign wr_status = REG_WR_I && REG_ADDR_I == STATUS_OFS;
  assign wr_mask   = REG_WR_I && REG_ADDR_I == MASK_OFS;
  assign clr       = wr_status ? REG_WDATA_I[EV_W-1:0] : '0;
  // an event in the clearing cycle survives the clear
  assign status_d  = (status_q & ~clr) | ev;
  assign mask_d    = wr_mask ? REG_WDATA_I[EV_W-1:0] : mask_q;
  assign flags     = {22'h0, ft_q, big_q, rx_byte, tx_byte,
                      RX_INPUT_READY_O, WIDE_PORT_INPUT_READY_O,
                      WIDE_PORT_OUTPUT_READY_O, WIDE_PORT_EMPTY_FLAG_N_O,
                      TX_PORT_OUTPUT_READY_O, TX_PORT_EMPTY_FLAG_N_O};
  assign rd_mux    = !REG_RD_I ? '0
                   : REG_ADDR_I == STATUS_OFS ? DATA_W'(status_q)
                   : REG_ADDR_I == MASK_OFS ? DATA_W'(mask_q)
                   : REG_ADDR_I == FLAGS_OFS ? flags
                   : '0;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      status_q    <= STATUS_RST;
      mask_q      <= MASK_RST;
      REG_RDATA_O <= '0;
      IRQ_O       <= 1'b0;
    end else if (CE_I) begin
      status_q    <= status_d;
      mask_q      <= mask_d;
      REG_RDATA_O <= rd_mux;
      IRQ_O       <= |(status_d & mask_d);
    end
  end

  // checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I || !CE_I);
  sequence low3_then_high(logic s);
    !s [*3] ##1 s;
  endsequence
  sequence low1_then_high(logic s);
    !s ##1 s;
  endsequence
  tx_ft_rise_a: assert property (
    (ft_q && f1_push && !$past(f1_push) && !f1_avail &&
     !TX_PORT_OUTPUT_READY_O) |-> ##1 low3_then_high(TX_PORT_OUTPUT_READY_O))
    else $error("transmit fall-through ready not on third clock");
  wide_ft_rise_a: assert property (
    (ft_q && f2_push && !$past(f2_push) && !f2_avail &&
     !WIDE_PORT_OUTPUT_READY_O)
    |-> ##1 low3_then_high(WIDE_PORT_OUTPUT_READY_O))
    else $error("wide fall-through ready not on third clock");
  // flag register lags the push by one edge, so low first, then high
  tx_ef_clear_a: assert property (
    (!ft_q && f1_push && !$past(f1_push) && !TX_PORT_EMPTY_FLAG_N_O)
    |-> ##1 low1_then_high(TX_PORT_EMPTY_FLAG_N_O))
    else $error("transmit empty flag not cleared next clock");
  wide_ef_clear_a: assert property (
    (!ft_q && f2_push && !WIDE_PORT_EMPTY_FLAG_N_O)
    |-> ##2 WIDE_PORT_EMPTY_FLAG_N_O)
    else $error("wide empty flag not cleared next clock");
  tx_ef_set_a: assert property (
    (!ft_q && tx_last_rd && !f1_avail_nx) |=> !TX_PORT_EMPTY_FLAG_N_O)
    else $error("transmit empty flag not set on last piece");
  tx_or_drop_a: assert property (
    (ft_q && tx_last_rd && !f1_avail) |=> !TX_PORT_OUTPUT_READY_O)
    else $error("transmit ready not dropped on last piece");
  wide_ir_rise_a: assert property (
    (f1_free && !WIDE_PORT_INPUT_READY_O) |-> ##2 WIDE_PORT_INPUT_READY_O)
    else $error("wide input ready not raised after free");
  tx_word_big_a: assert property (
    (f1_pop && !tx_byte && big_q)
    |=> TX_DATA_O == $past(f1_head[LW_W-1:NW_W]))
    else $error("big-endian word read not upper half first");
  tx_byte_lit_a: assert property (
    (f1_pop && tx_byte && !big_q)
    |=> TX_DATA_O == {9'h000, $past(f1_head[BYTE_W-1:0])})
    else $error("little-endian byte read not low byte first");
  rx_word_big_a: assert property (
    (f2_push && !rx_byte && big_q)
    |-> f2_wdata == {rx_lw_q[LW_W-1:NW_W], RX_DATA_I})
    else $error("big-endian word pair misplaced");
  rx_byte_lit_a: assert property (
    (f2_push && rx_byte && !big_q)
    |-> f2_wdata == {RX_DATA_I[BYTE_W-1:0], rx_lw_q[LW_W-BYTE_W-1:0]})
    else $error("little-endian last byte not on top");
  endian_hold_a: assert property (
    !$past(RESET_I) |-> $stable(big_q))
    else $error("endian choice changed outside reset");
endmodule

// >>> tb/fbm_host.sv
// host-side model holding the configuration pins of the fifo pair
`timescale 1ns/1ps
module fbm_host
  import fbm_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [CFG_W-1:0] cfg_i,
  output logic                  tx_sel_o,
  output logic                  rx_sel_o,
  output logic                  endian_o,
  output logic                  ft_o
);
  logic [CFG_W-1:0] cfg_q;
  logic             wobble_q;

  // widths only change while the device is held in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q    <= cfg_i;
      wobble_q <= 1'b0;
    end else begin
      wobble_q <= ~wobble_q;
    end
  end

  assign tx_sel_o = cfg_q[CFG_TX_BYTE];
  assign rx_sel_o = cfg_q[CFG_RX_BYTE];
  // no kinder than a real host: latched endian and timing pins wander once out of reset
  assign endian_o = cfg_q[CFG_BIG] ^ wobble_q;
  assign ft_o     = cfg_q[CFG_FT] ^ wobble_q;
endmodule

// >>> tb/fifo_bus_matching_width_converter_tb.sv
// self-checking bench for the bus-matching fifo pair
`timescale 1ns/1ps
module fifo_bus_matching_width_converter_tb
  import fbm_pkg::*;
;
  localparam logic [8:0] BA = 9'h101, BB = 9'h0b2, BC = 9'h0c3, BD = 9'h1d4;
  localparam logic [LW_W-1:0] LW = {BA, BB, BC, BD};
  typedef struct {
    logic [CFG_W-1:0] c;
    logic [NW_W-1:0]  p [4];
  } fbm_row_t;
  // cfg is {ft, big, rx byte, tx byte}; pieces in port order
  fbm_row_t rows [4] = '{
    '{4'h4, '{{BA, BB}, {BC, BD}, 18'h0, 18'h0}},
    '{4'h0, '{{BC, BD}, {BA, BB}, 18'h0, 18'h0}},
    '{4'h7, '{{9'h0, BA}, {9'h0, BB}, {9'h0, BC}, {9'h0, BD}}},
    '{4'h3, '{{9'h0, BD}, {9'h0, BC}, {9'h0, BB}, {9'h0, BA}}}};

  logic              clk, rst;
  logic [CFG_W-1:0]  cfg;
  logic              tx_sel, rx_sel, endian, ft;
  logic              wide_wr, wide_rd, tx_rd, rx_wr, reg_wr, reg_rd;
  logic [LW_W-1:0]   wide_wdata, wide_rdata, w;
  logic [NW_W-1:0]   rx_data, tx_data, d;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, r;
  logic              wide_ir, wide_or, wide_ef_n, tx_or, tx_ef_n, rx_ir, irq;
  int                mismatches, num_checks, n;
  int                cycles = 0;

  fbm_host host (.clk_i(clk), .rst_i(rst), .cfg_i(cfg), .tx_sel_o(tx_sel),
    .rx_sel_o(rx_sel), .endian_o(endian), .ft_o(ft));

  fbm_top #(.DEPTH(4)) dut (.CLK_I(clk), .RESET_I(rst), .CE_I(1'b1),
    .TX_PORT_WIDTH_SELECT_I(tx_sel), .RX_PORT_WIDTH_SELECT_I(rx_sel),
    .ENDIAN_ORDER_SELECT_I(endian), .FALL_THROUGH_MODE_I(ft),
    .WIDE_WR_I(wide_wr), .WIDE_WDATA_I(wide_wdata), .WIDE_RD_I(wide_rd),
    .WIDE_RDATA_O(wide_rdata), .WIDE_PORT_INPUT_READY_O(wide_ir),
    .WIDE_PORT_OUTPUT_READY_O(wide_or), .WIDE_PORT_EMPTY_FLAG_N_O(wide_ef_n),
    .TX_RD_I(tx_rd), .TX_DATA_O(tx_data), .TX_PORT_OUTPUT_READY_O(tx_or),
    .TX_PORT_EMPTY_FLAG_N_O(tx_ef_n), .RX_WR_I(rx_wr), .RX_DATA_I(rx_data),
    .RX_INPUT_READY_O(rx_ir), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
    .IRQ_O(irq));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string what, logic [LW_W-1:0] seen,
                       logic [LW_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic flag(string what, logic seen, logic exp);
    check(what, {35'h0, seen}, {35'h0, exp});
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // every strobe task returns just after the edge that takes it
  task automatic wide_write(logic [LW_W-1:0] v);
    @(posedge clk);
    wide_wr <= 1'b1;
    wide_wdata <= v;
    @(posedge clk);
    wide_wr <= 1'b0;
    wide_wdata <= ~v;
    #1;
  endtask

  task automatic rx_write(logic [NW_W-1:0] v);
    @(posedge clk);
    rx_wr <= 1'b1;
    rx_data <= v;
    @(posedge clk);
    rx_wr <= 1'b0;
    rx_data <= ~v;
    #1;
  endtask

  task automatic tx_read(output logic [NW_W-1:0] v);
    @(posedge clk);
    tx_rd <= 1'b1;
    @(posedge clk);
    tx_rd <= 1'b0;
    #1;
    v = tx_data;
  endtask

  task automatic wide_read(output logic [LW_W-1:0] v);
    @(posedge clk);
    wide_rd <= 1'b1;
    @(posedge clk);
    wide_rd <= 1'b0;
    #1;
    v = wide_rdata;
  endtask

  task automatic reg_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    #1;
  endtask

  task automatic reg_read(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic do_reset(logic [CFG_W-1:0] c);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    repeat (8) @(posedge clk);
    #1;
    check("reset flags", {32'h0, wide_ir, rx_ir, tx_ef_n, wide_ef_n}, 36'h0);
    @(posedge clk);
    rst <= 1'b0;
    tick(2);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    {rst, wide_wr, wide_rd, tx_rd, rx_wr, reg_wr, reg_rd} = 7'h40;
    {cfg, wide_wdata, rx_data, reg_addr, reg_wdata} = '0;
    {mismatches, num_checks} = '0;
    foreach (rows[i]) begin
      do_reset(rows[i].c);
      n = rows[i].c[CFG_TX_BYTE] ? 4 : 2;
      wide_write(LW);
      flag("tx empty", tx_ef_n, 1'b0);
      tick(1);
      flag("tx empty", tx_ef_n, 1'b1);
      for (int k = 0; k < n; k++) begin
        tx_read(d);
        // upper lines are zero-filled in byte mode and are not compared
        check("tx piece", {18'h0, n == 4 ? {9'h0, d[8:0]} : d},
              {18'h0, rows[i].p[k]});
        flag("tx empty", tx_ef_n, k < n - 1);
      end
      for (int k = 0; k < n; k++) begin
        rx_write(rows[i].p[k]);
        flag("wide empty", wide_ef_n, 1'b0);
      end
      tick(1);
      flag("wide empty", wide_ef_n, 1'b1);
      wide_read(w);
      check("wide word", w, LW);
      $display("table row %0d done", i);
    end

    do_reset(4'hc);
    wide_write(LW);
    tick(2);
    flag("tx ready", tx_or, 1'b0);
    tick(1);
    flag("tx ready", tx_or, 1'b1);
    check("tx piece", {18'h0, tx_data}, {18'h0, BA, BB});
    tx_read(d);
    check("tx piece", {18'h0, d}, {18'h0, BC, BD});
    flag("tx ready", tx_or, 1'b1);
    tx_read(d);
    flag("tx ready", tx_or, 1'b0);
    rx_write({BA, BB});
    rx_write({BC, BD});
    tick(2);
    flag("wide ready", wide_or, 1'b0);
    tick(1);
    flag("wide ready", wide_or, 1'b1);
    check("wide word", wide_rdata, LW);
    $display("fall-through test done");

    do_reset(4'h4);
    reg_read(MASK_OFS, r);
    check("mask reset", {4'h0, r}, {30'h0, MASK_RST});
    for (int k = 0; k < 4; k++) wide_write(LW + k);
    tick(1);
    flag("wide in ready", wide_ir, 1'b0);
    wide_write(~LW);
    tick(2);
    flag("irq masked", irq, 1'b0);
    reg_write(MASK_OFS, 32'h4);
    tick(1);
    flag("irq", irq, 1'b1);
    tx_read(d);
    flag("wide in ready", wide_ir, 1'b0);
    tx_read(d);
    flag("wide in ready", wide_ir, 1'b0);
    tick(1);
    flag("wide in ready", wide_ir, 1'b1);
    reg_read(STATUS_OFS, r);
    check("status", {4'h0, r}, 36'h5);
    reg_write(STATUS_OFS, 32'h5);
    tick(1);
    flag("irq", irq, 1'b0);
    reg_read(4'hc, r);
    check("unmapped", {4'h0, r}, 36'h0);
    $display("full and interrupt test done");
    summarize();
  end
endmodule
